// ### srcp_command_profiles.sv
// Profile selection, command translation and serial framing for reader links
`default_nettype none
`include "srcp_params.svh"
module srcp_command_profiles (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Profile selector pins
  input wire logic [3:0] profileSelectSwitch,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // Serial link
  output logic serialTx,
  input wire logic serialRx
);
  logic rstMeta_n;
  logic rstSync_n;
  logic [1:0] swMeta;
  logic [3:0] swSync0;
  logic [3:0] swSync1;
  logic rxMeta;
  logic rxSync;
  logic profileLatched;
  srcp_pkg::srcp_profile_t profile;
  logic [15:0] ctrlWord;
  logic [15:0] ctrlPrev;
  logic [15:0] pending;
  logic [15:0] rise;
  logic [15:0] fall;
  logic gateClosePend;
  logic cmdActive;
  logic [31:0] cmdBytes;
  logic [2:0] cmdLen;
  logic [2:0] cmdIdx;
  srcp_pkg::srcp_frame_t frame;
  logic [7:0] pushData;
  logic pushValid;
  logic pushReady;
  logic txValid;
  logic [7:0] txData;
  logic txReady;
  srcp_pkg::srcp_shift_t shState;
  logic [15:0] baudCnt;
  logic [2:0] bitIdx;
  logic [7:0] shReg;
  logic [7:0] rxLast;
  logic [15:0] dropCount;
  logic [3:0] pickBit;
  logic pickClose;
  logic pickFound;

  // Command table: 4 bytes, first byte in the top lane, and its length
  function automatic logic [34:0] cmdLookup(input srcp_pkg::srcp_profile_t p, input logic [3:0] b,
                                            input logic close);
    logic [34:0] r;
    r = '0;
    case (p)
      srcp_pkg::PROF_BAR: begin
        case (b)
          4'h0: r = {3'd1, `SRCP_CH_V, 24'h00_0000};
          4'h1: r = {3'd1, (close ? `SRCP_CH_MINUS : `SRCP_CH_PLUS), 24'h00_0000};
          4'h2: r = {3'd2, `SRCP_CH_1, `SRCP_CH_1, 16'h0000};
          4'h3: r = {3'd2, `SRCP_CH_1, `SRCP_CH_2, 16'h0000};
          4'h4: r = {3'd2, `SRCP_CH_1, `SRCP_CH_3, 16'h0000};
          4'hE: r = {3'd4, `SRCP_CH_P, `SRCP_CH_C, `SRCP_CH_2, `SRCP_CH_0};
          4'hF: r = {3'd1, `SRCP_CH_H, 24'h00_0000};
          default: r = '0;
        endcase
      end
      srcp_pkg::PROF_2D: begin
        case (b)
          4'h0: r = {3'd1, `SRCP_CH_LI, 24'h00_0000};
          4'h1: r = {3'd1, (close ? `SRCP_CH_DC4 : `SRCP_CH_DC2), 24'h00_0000};
          default: r = '0;
        endcase
      end
      srcp_pkg::PROF_IMG: begin
        case (b)
          4'h0: r = {3'd1, `SRCP_CH_V, 24'h00_0000};
          4'h1: r = close ? 35'h0 : {3'd1, `SRCP_CH_PLUS, 24'h00_0000};
          default: r = '0;
        endcase
      end
      default: r = '0;
    endcase
    return r;
  endfunction : cmdLookup

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      swSync0 <= 4'h0;
      swSync1 <= 4'h0;
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      swMeta <= 2'b00;
    end else begin
      swSync0 <= profileSelectSwitch;
      swSync1 <= swSync0;
      rxMeta <= serialRx;
      rxSync <= rxMeta;
      swMeta <= {swMeta[0], 1'b1};
    end
  end

  // Switch is caught once, after the synchroniser has filled
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      profile <= srcp_pkg::PROF_NONE;
      profileLatched <= 1'b0;
    end else if (!profileLatched && swMeta[1]) begin
      profileLatched <= 1'b1;
      case (swSync1)
        `SRCP_POS_BAR: profile <= srcp_pkg::PROF_BAR;
        `SRCP_POS_2D: profile <= srcp_pkg::PROF_2D;
        `SRCP_POS_IMG: profile <= srcp_pkg::PROF_IMG;
        `SRCP_POS_HAND: profile <= srcp_pkg::PROF_HAND;
        default: profile <= srcp_pkg::PROF_NONE;
      endcase
    end
  end

  // Control word written by the fieldbus side
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrlWord <= 16'h0000;
      ctrlPrev <= 16'h0000;
    end else begin
      ctrlPrev <= ctrlWord;
      if (regWrite && regAddr == `SRCP_REG_CTRL) begin
        ctrlWord <= regWrData;
      end
    end
  end

  assign rise = ctrlWord & ~ctrlPrev;
  assign fall = ~ctrlWord & ctrlPrev;

  // Lowest pending bit wins, but the gate close request goes first once bit 1 is no longer pending
  always_comb begin
    pickBit = 4'h0;
    pickClose = 1'b0;
    pickFound = 1'b0;
    if (gateClosePend && !pending[`SRCP_BIT_GATE]) begin
      pickBit = 4'h1;
      pickClose = 1'b1;
      pickFound = 1'b1;
    end else begin
      for (int i = 15; i >= 0; i--) begin
        if (pending[i]) begin
          pickBit = 4'(i);
          pickFound = 1'b1;
        end
      end
    end
  end

  // Edge capture; the set of a new edge wins over the clear of a served one
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pending <= 16'h0000;
      gateClosePend <= 1'b0;
    end else begin
      logic [15:0] nextPending;
      logic nextClose;
      nextPending = pending;
      nextClose = gateClosePend;
      if (!cmdActive && frame == srcp_pkg::TX_IDLE && pickFound) begin
        if (pickClose) begin
          nextClose = 1'b0;
        end else begin
          nextPending[pickBit] = 1'b0;
        end
      end
      if (ctrlWord[`SRCP_BIT_CMDMODE] && profile != srcp_pkg::PROF_HAND) begin
        nextPending = nextPending | rise;
        if (fall[`SRCP_BIT_GATE]) begin
          nextClose = 1'b1;
        end
      end
      pending <= nextPending;
      gateClosePend <= nextClose;
    end
  end

  // Command loader and telegram framer
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cmdActive <= 1'b0;
      cmdBytes <= 32'h0000_0000;
      cmdLen <= 3'd0;
      cmdIdx <= 3'd0;
      frame <= srcp_pkg::TX_IDLE;
    end else if (!cmdActive) begin
      if (pickFound) begin
        logic [34:0] entry;
        entry = cmdLookup(profile, pickBit, pickClose);
        if (entry[34:32] != 3'd0) begin
          cmdActive <= 1'b1;
          cmdBytes <= entry[31:0];
          cmdLen <= entry[34:32];
          cmdIdx <= 3'd0;
          frame <= (profile == srcp_pkg::PROF_HAND) ? srcp_pkg::TX_BODY : srcp_pkg::TX_STX;
        end
      end
    end else if (pushReady) begin
      case (frame)
        srcp_pkg::TX_STX: frame <= srcp_pkg::TX_BODY;
        srcp_pkg::TX_BODY: begin
          cmdBytes <= {cmdBytes[23:0], 8'h00};
          cmdIdx <= cmdIdx + 3'd1;
          if (cmdIdx + 3'd1 == cmdLen) begin
            frame <= srcp_pkg::TX_CR;
          end
        end
        srcp_pkg::TX_CR: frame <= srcp_pkg::TX_LF;
        srcp_pkg::TX_LF: begin
          frame <= srcp_pkg::TX_IDLE;
          cmdActive <= 1'b0;
        end
        default: frame <= srcp_pkg::TX_IDLE;
      endcase
    end
  end

  always_comb begin
    case (frame)
      srcp_pkg::TX_STX: pushData = `SRCP_CH_STX;
      srcp_pkg::TX_BODY: pushData = cmdBytes[31:24];
      srcp_pkg::TX_CR: pushData = `SRCP_CH_CR;
      srcp_pkg::TX_LF: pushData = `SRCP_CH_LF;
      default: pushData = 8'h00;
    endcase
  end
  assign pushValid = cmdActive && frame != srcp_pkg::TX_IDLE;

  srcp_fifo #(.WIDTH(`SRCP_DATA_BITS), .DEPTH(`SRCP_FIFO_DEPTH)) txFifo (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(pushReady),
    .outValid(txValid),
    .outData(txData),
    .outReady(txReady)
  );

  // 8N1 transmitter at the fixed default rate, no flow control
  assign txReady = (shState == srcp_pkg::SH_IDLE);
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      shState <= srcp_pkg::SH_IDLE;
      baudCnt <= 16'h0000;
      bitIdx <= 3'd0;
      shReg <= 8'h00;
      serialTx <= 1'b1;
    end else begin
      case (shState)
        srcp_pkg::SH_IDLE: begin
          serialTx <= 1'b1;
          if (txValid) begin
            shReg <= txData;
            shState <= srcp_pkg::SH_START;
            baudCnt <= 16'(`SRCP_BAUD_DIV - 1);
            serialTx <= 1'b0;
          end
        end
        srcp_pkg::SH_START, srcp_pkg::SH_DATA, srcp_pkg::SH_STOP: begin
          if (baudCnt != 16'h0000) begin
            baudCnt <= baudCnt - 16'h0001;
          end else begin
            baudCnt <= 16'(`SRCP_BAUD_DIV - 1);
            if (shState == srcp_pkg::SH_START) begin
              shState <= srcp_pkg::SH_DATA;
              bitIdx <= 3'd0;
              serialTx <= shReg[0];
            end else if (shState == srcp_pkg::SH_DATA) begin
              if (bitIdx == 3'd7) begin
                shState <= srcp_pkg::SH_STOP;
                serialTx <= 1'b1;
              end else begin
                bitIdx <= bitIdx + 3'd1;
                serialTx <= shReg[3'd1 + bitIdx];
              end
            end else begin
              shState <= srcp_pkg::SH_IDLE;
            end
          end
        end
        default: shState <= srcp_pkg::SH_IDLE;
      endcase
    end
  end

  // Line level sampled for status only; reply parsing lives elsewhere
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rxLast <= 8'h00;
      dropCount <= 16'h0000;
    end else begin
      rxLast <= {rxLast[6:0], rxSync};
      if (regWrite && regAddr == `SRCP_REG_CTRL && !regWrData[`SRCP_BIT_CMDMODE] && (|regWrData[15:1])) begin
        dropCount <= dropCount + 16'h0001;
      end
    end
  end

  // Read port: data stand one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        `SRCP_REG_CTRL: regRdData <= ctrlWord;
        `SRCP_REG_STATUS: regRdData <= {10'h000, profileLatched, cmdActive, txValid, !pushReady,
                                        shState != srcp_pkg::SH_IDLE, gateClosePend};
        `SRCP_REG_TXDATA: regRdData <= pending;
        `SRCP_REG_PROFILE: regRdData <= {13'h0000, profile};
        `SRCP_REG_RXDATA: regRdData <= {rxLast, 8'h00} | {8'h00, dropCount[7:0]};
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule : srcp_command_profiles
`default_nettype wire

// ### srcp_params.svh
// Constants for the serial reader command profile block
`ifndef SRCP_PARAMS_SVH
`define SRCP_PARAMS_SVH

`define SRCP_CLK_HZ 40000000
`define SRCP_BAUD 9600
`define SRCP_BAUD_DIV (`SRCP_CLK_HZ / `SRCP_BAUD)
`define SRCP_DATA_BITS 8
`define SRCP_FIFO_DEPTH 16
`define SRCP_CMD_MAXLEN 4

// Register offsets
`define SRCP_REG_CTRL 4'h0
`define SRCP_REG_STATUS 4'h1
`define SRCP_REG_TXDATA 4'h2
`define SRCP_REG_PROFILE 4'h3
`define SRCP_REG_RXDATA 4'h4

// Control word bit positions
`define SRCP_BIT_CMDMODE 0
`define SRCP_BIT_GATE 1

// Characters
`define SRCP_CH_STX 8'h02
`define SRCP_CH_CR 8'h0D
`define SRCP_CH_LF 8'h0A
`define SRCP_CH_DC2 8'h12
`define SRCP_CH_DC4 8'h14
`define SRCP_CH_V 8'h56
`define SRCP_CH_LI 8'h69
`define SRCP_CH_PLUS 8'h2B
`define SRCP_CH_MINUS 8'h2D
`define SRCP_CH_1 8'h31
`define SRCP_CH_2 8'h32
`define SRCP_CH_3 8'h33
`define SRCP_CH_0 8'h30
`define SRCP_CH_P 8'h50
`define SRCP_CH_C 8'h43
`define SRCP_CH_H 8'h48

// Profile switch positions
`define SRCP_POS_BAR 4'h5
`define SRCP_POS_2D 4'h6
`define SRCP_POS_IMG 4'h7
`define SRCP_POS_HAND 4'h8

`endif

// ### srcp_pkg.sv
// Types for the serial reader command profile block
`default_nettype none
package srcp_pkg;
  typedef enum logic [2:0] {PROF_NONE, PROF_BAR, PROF_2D, PROF_IMG, PROF_HAND} srcp_profile_t;
  typedef enum logic [2:0] {TX_IDLE, TX_STX, TX_BODY, TX_CR, TX_LF} srcp_frame_t;
  typedef enum logic [1:0] {SH_IDLE, SH_START, SH_DATA, SH_STOP} srcp_shift_t;
endpackage : srcp_pkg
`default_nettype wire

// ### srcp_fifo.sv
// Byte FIFO with valid/ready on both sides
`default_nettype none
module srcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstSync_n,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWrite;
  logic doRead;
  logic [AW-1:0] nextRd;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign nextRd = doRead ? rdPtr + 1'b1 : rdPtr;

  // Read word is registered; a write into the slot about to be shown passes straight through
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
    outData <= (doWrite && wrPtr == nextRd) ? inData : mem[nextRd];
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
      case ({doWrite, doRead})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : srcp_fifo
`default_nettype wire

// ### srcp_command_profiles_sva.sv
// Port checker for the serial reader command profile block
`default_nettype none
`include "srcp_params.svh"
module srcp_command_profiles_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Inputs
  input wire logic [3:0] profileSelectSwitch,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic serialRx,
  // Outputs
  input wire logic [15:0] regRdData,
  input wire logic serialTx
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = `SRCP_BAUD_DIV;
  int runLen;
  logic lastTx;
  logic [15:0] ctrlShadow;
  logic ctrlWr;
  logic lineIdle;
  logic [2:0] expProf;
  assign ctrlWr = regWrite && regAddr == `SRCP_REG_CTRL;
  assign lineIdle = serialTx && lastTx && runLen >= 11 * BIT;
  assign expProf = (profileSelectSwitch >= 4'h5 && profileSelectSwitch <= 4'h8) ? 3'(profileSelectSwitch - 4'h4) : 3'h0;
  // A line held at mark through reset counts as long idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      runLen <= 11 * BIT;
      lastTx <= 1'b1;
    end else begin
      runLen <= (serialTx != lastTx) ? 1 : runLen + 1;
      lastTx <= serialTx;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) ctrlShadow <= 16'h0000;
    else if (ctrlWr) ctrlShadow <= regWrData;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_rdQuiet; !$past(regRead) |-> regRdData == 16'h0000; endproperty
  a_rdQuiet: assert property (p_rdQuiet) else $error("read data not zero outside its slot");
  property p_profRead; regRead && regAddr == `SRCP_REG_PROFILE |=> regRdData == {13'h0000, expProf}; endproperty
  a_profRead: assert property (p_profRead) else $error("profile code does not match switch");
  property p_bitTime; $rose(serialTx) |-> runLen % BIT == 0; endproperty
  a_bitTime: assert property (p_bitTime) else $error("low run not a whole number of bits");
  property p_stopBit; $fell(serialTx) |-> runLen >= BIT; endproperty
  a_stopBit: assert property (p_stopBit) else $error("mark shorter than one bit");
  property p_handSilent; profileSelectSwitch == `SRCP_POS_HAND |-> serialTx; endproperty
  a_handSilent: assert property (p_handSilent) else $error("hand-held profile sent a command");
  property p_cmdOff; ctrlWr && !regWrData[0] && lineIdle |=> serialTx [*8]; endproperty
  a_cmdOff: assert property (p_cmdOff) else $error("command sent with command mode off");
  property p_edgeSends;
    ctrlWr && regWrData[0] && !ctrlShadow[0] && lineIdle && profileSelectSwitch >= 4'h5 && profileSelectSwitch <= 4'h7
      |-> ##[1:200] !serialTx;
  endproperty
  a_edgeSends: assert property (p_edgeSends) else $error("no telegram after command mode edge");
  property p_noEdge; ctrlWr && regWrData == ctrlShadow && lineIdle |=> serialTx [*8]; endproperty
  a_noEdge: assert property (p_noEdge) else $error("telegram sent without a bit edge");
  c_edge: cover property (ctrlWr && regWrData[0] && !ctrlShadow[0]);
  c_byte: cover property ($rose(serialTx));
  c_prof: cover property (regRead && regAddr == `SRCP_REG_PROFILE);
endmodule : srcp_command_profiles_sva
bind srcp_command_profiles srcp_command_profiles_sva u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
  .profileSelectSwitch(profileSelectSwitch), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .serialRx(serialRx), .regRdData(regRdData), .serialTx(serialTx));
`default_nettype wire

// ### srcp_reader_model.sv
// Behavioural code reader at the far end of the serial link
`default_nettype none
`include "srcp_params.svh"
module srcp_reader_model (
  // Clock
  input wire logic clk_sys,
  // Serial link
  input wire logic lineIn,
  output logic lineOut
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = `SRCP_BAUD_DIV;
  logic [7:0] rxQ[$];
  int frameErrs;
  logic [7:0] shiftByte;
  // The reader stays silent here, so its line rests at mark
  initial begin
    lineOut = 1'b1;
    frameErrs = 0;
  end
  // 8N1, LSB first, sampled mid bit; bytes kept whole so framing is judged by the bench
  always begin
    @(posedge clk_sys iff lineIn === 1'b0);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_sys);
      shiftByte[i] = lineIn;
    end
    repeat (BIT) @(posedge clk_sys);
    if (lineIn !== 1'b1) frameErrs++;
    rxQ.push_back(shiftByte);
  end
endmodule : srcp_reader_model
`default_nettype wire

// ### srcp_command_profiles_bench.sv
// Self-checking bench for the serial reader command profile block
`default_nettype none
`include "srcp_params.svh"
module srcp_command_profiles_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys;
  logic reset_n;
  logic [3:0] profileSelectSwitch;
  logic [3:0] regAddr;
  logic [15:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [15:0] regRdData;
  logic serialTx;
  logic serialRx;
  int failCount;
  int testsRun;
  int nOff;
  logic [15:0] rd;
  logic [15:0] val;
  logic [7:0] pushQ[$];
  logic [7:0] expQ[$];
  srcp_command_profiles dut (.clk_sys(clk_sys), .reset_n(reset_n), .profileSelectSwitch(profileSelectSwitch),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .serialTx(serialTx), .serialRx(serialRx));
  srcp_reader_model reader (.clk_sys(clk_sys), .lineIn(serialTx), .lineOut(serialRx));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Bytes entering the transmit queue; a burst lands long before the slow line drains it
  always @(posedge clk_sys) begin
    if (dut.pushValid && dut.pushReady) pushQ.push_back(dut.pushData);
  end
  function automatic logic [15:0] expProfile(input logic [3:0] sw);
    return (sw >= 4'h5 && sw <= 4'h8) ? 16'(sw - 4'h4) : 16'h0000;
  endfunction : expProfile
  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : endOfTest
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask : regWr
  task automatic regRd(input logic [3:0] a, output logic [15:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
    @(posedge clk_sys);
  endtask : regRd
  // Bounded so a silent link cannot hang the run
  task automatic waitBytes(input int n);
    int k;
    for (k = 0; k < (n * 10 + 2) * `SRCP_BAUD_DIV && reader.rxQ.size() < n; k++) @(posedge clk_sys);
    if (reader.rxQ.size() < n) begin
      failCount++;
      $display("ERROR %0t serial bytes missing", $time);
      endOfTest();
    end
  endtask : waitBytes
  // Expected telegram: STX if framed, payload from the top byte down, then CR LF
  task automatic addFrame(input logic stx, input logic [31:0] body, input int len);
    if (stx) expQ.push_back(`SRCP_CH_STX);
    for (int i = 0; i < len; i++) expQ.push_back(body[31 - 8 * i -: 8]);
    expQ.push_back(`SRCP_CH_CR);
    expQ.push_back(`SRCP_CH_LF);
  endtask : addFrame
  // Only a full queue plus the byte in the shifter can be taken before the first byte ends
  task automatic checkPushes();
    int n;
    n = (expQ.size() > `SRCP_FIFO_DEPTH + 1) ? `SRCP_FIFO_DEPTH + 1 : expQ.size();
    check(16'(pushQ.size()), 16'(n));
    for (int i = 0; i < n && i < pushQ.size(); i++) check(16'(pushQ[i]), 16'(expQ[i]));
  endtask : checkPushes
  // The switch is caught once after release, so each profile needs its own reset
  task automatic restart(input logic [3:0] sw);
    reset_n <= 1'b0;
    profileSelectSwitch <= sw;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    pushQ.delete();
    expQ.delete();
    regRd(`SRCP_REG_PROFILE, rd);
    check(rd, expProfile(sw));
    regRd(`SRCP_REG_STATUS, rd);
    check(rd, 16'h0020);
  endtask : restart
  initial begin
    reset_n = 1'b0;
    profileSelectSwitch = `SRCP_POS_BAR;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    failCount = 0;
    testsRun = 0;
    void'($urandom(26198));
    restart(`SRCP_POS_BAR);
    regWr(`SRCP_REG_PROFILE, 16'($urandom));
    regRd(`SRCP_REG_PROFILE, rd);
    check(rd, expProfile(profileSelectSwitch));
    regRd(4'h9, rd);
    check(rd, 16'h0000);
    // Edges with command mode off must be dropped, not queued
    nOff = 3 + $urandom_range(3);
    for (int i = 0; i < nOff; i++) begin
      val = (16'($urandom) & 16'hFFFE) | 16'h0002;
      regWr(`SRCP_REG_CTRL, val);
    end
    regWr(`SRCP_REG_CTRL, val);
    regRd(`SRCP_REG_RXDATA, rd);
    check(rd, {8'hFF, 8'(nOff + 1)});
    regWr(`SRCP_REG_CTRL, 16'h0000);
    repeat (200) @(posedge clk_sys);
    check(16'(reader.rxQ.size()), 16'h0000);
    check(16'(pushQ.size()), 16'h0000);
    regWr(`SRCP_REG_CTRL, 16'h0003);
    regWr(`SRCP_REG_CTRL, 16'h0001);
    addFrame(1'b1, {`SRCP_CH_V, 24'h00_0000}, 1);
    addFrame(1'b1, {`SRCP_CH_PLUS, 24'h00_0000}, 1);
    addFrame(1'b1, {`SRCP_CH_MINUS, 24'h00_0000}, 1);
    waitBytes(2);
    check(16'(reader.rxQ[0]), 16'(`SRCP_CH_STX));
    check(16'(reader.rxQ[1]), 16'(`SRCP_CH_V));
    check(16'(reader.frameErrs), 16'h0000);
    checkPushes();
    // Reset in mid telegram, coming back as the hand-held profile
    restart(`SRCP_POS_HAND);
    reader.rxQ.delete();
    for (int i = 0; i < 4; i++) begin
      regWr(`SRCP_REG_CTRL, 16'($urandom) | 16'h0001);
      regWr(`SRCP_REG_CTRL, 16'h0000);
    end
    repeat (2000) @(posedge clk_sys);
    check(16'(reader.rxQ.size()), 16'h0000);
    check(16'(pushQ.size()), 16'h0000);
    // Bar code profile, mode strings with unmapped bits set in the same write
    restart(`SRCP_POS_BAR);
    regWr(`SRCP_REG_CTRL, 16'hC01D | (16'($urandom) & 16'h3FE0));
    addFrame(1'b1, {`SRCP_CH_V, 24'h00_0000}, 1);
    addFrame(1'b1, {`SRCP_CH_1, `SRCP_CH_1, 16'h0000}, 2);
    addFrame(1'b1, {`SRCP_CH_1, `SRCP_CH_2, 16'h0000}, 2);
    addFrame(1'b1, {`SRCP_CH_1, `SRCP_CH_3, 16'h0000}, 2);
    repeat (100) @(posedge clk_sys);
    checkPushes();
    restart(`SRCP_POS_BAR);
    regWr(`SRCP_REG_CTRL, 16'hC001);
    addFrame(1'b1, {`SRCP_CH_V, 24'h00_0000}, 1);
    addFrame(1'b1, {`SRCP_CH_P, `SRCP_CH_C, `SRCP_CH_2, `SRCP_CH_0}, 4);
    addFrame(1'b1, {`SRCP_CH_H, 24'h00_0000}, 1);
    repeat (100) @(posedge clk_sys);
    checkPushes();
    // 2D reader then image reader: gate open and close with random unused bits
    for (int p = 0; p < 2; p++) begin
      restart((p == 0) ? `SRCP_POS_2D : `SRCP_POS_IMG);
      val = (16'($urandom) & 16'hFFFC) | 16'h0003;
      regWr(`SRCP_REG_CTRL, val);
      regWr(`SRCP_REG_CTRL, val & 16'hFFFD);
      addFrame(1'b1, {((p == 0) ? `SRCP_CH_LI : `SRCP_CH_V), 24'h00_0000}, 1);
      addFrame(1'b1, {((p == 0) ? `SRCP_CH_DC2 : `SRCP_CH_PLUS), 24'h00_0000}, 1);
      if (p == 0) addFrame(1'b1, {`SRCP_CH_DC4, 24'h00_0000}, 1);
      repeat (100) @(posedge clk_sys);
      checkPushes();
    end
    endOfTest();
  end
endmodule : srcp_command_profiles_bench
`default_nettype wire
